// file: hw/ovr_pkg.sv
// constants, register map and field layout of the over-range and timestamp block
// assumes a single 25 MHz clock and an Avalon-MM slave with 32-bit data
package ovr_pkg;
    // ****************************************************************
    // widths
    // ****************************************************************
    localparam int SAMPLE_W = 12;
    localparam int MAG_W = 11;
    localparam int CMP_W = 8;
    localparam int CHAN_N = 4;
    localparam int HOLD_SEL_W = 3;
    localparam int HOLD_CNT_W = 11;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    // ****************************************************************
    // register byte offsets
    // ****************************************************************
    localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] REG_THRESH = 4'h4;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h8;
    localparam logic [ADDR_W-1:0] REG_MASK = 4'hC;
    // ****************************************************************
    // control fields
    // ****************************************************************
    localparam int CTRL_DET_EN = 0;
    localparam int CTRL_HOLD_LO = 1;
    localparam int CTRL_RECV_EN = 4;
    localparam int CTRL_INS_EN = 5;
    localparam int CTRL_TRIG_EN = 6;
    localparam int CTRL_TRIG_SRC_LO = 7;
    localparam int CTRL_DIVIDED_REF_ON_C = 9;
    localparam int CTRL_DIVIDED_REF_ON_D = 10;
    localparam int CTRL_W = 11;
    localparam logic [1:0] TRIG_SRC_MARK = 2'h3;
    localparam logic [CMP_W-1:0] THRESH_RESET = 8'hFF;
    localparam logic [MAG_W-1:0] MAG_MAX = 11'h7FF;
    localparam logic [HOLD_CNT_W-1:0] HOLD_BASE = 11'h008;
    // status bits: 0..3 flag rise per channel, 4 mark rise
    localparam int STAT_W = 5;
    localparam int STAT_MARK = 4;
    // mark path: 3 sync stages, samples also delayed to match
    localparam int SYNC_N = 3;
endpackage : ovr_pkg

// file: hw/range_chan.sv
// one channel: magnitude, compare and hold count for the over-range flag
// assumes samples arrive every clock on the sample clock
`timescale 1ns/1ps
`default_nettype none
module range_chan (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // configuration
    input wire logic detect_enable_in,
    input wire logic [ovr_pkg::CMP_W-1:0] threshold_in,
    input wire logic [ovr_pkg::HOLD_SEL_W-1:0] hold_select_in,
    // sample
    input wire logic [ovr_pkg::SAMPLE_W-1:0] sample_in,
    // flag
    output logic flag_out
);
    import ovr_pkg::*;
    logic [MAG_W-1:0] mag;
    logic [CMP_W-1:0] cmp_byte;
    logic hit;
    logic [HOLD_CNT_W-1:0] cnt_q;
    logic [SAMPLE_W-1:0] neg;

    always_comb begin
        neg = SAMPLE_W'(~sample_in + 1'b1);
        if (!sample_in[SAMPLE_W-1]) begin
            mag = sample_in[MAG_W-1:0];
        end else if (sample_in[MAG_W-1:0] == '0) begin
            mag = MAG_MAX;
        end else begin
            mag = neg[MAG_W-1:0];
        end
    end
    assign cmp_byte = mag[MAG_W-1:MAG_W-CMP_W];
    assign hit = detect_enable_in && (cmp_byte >= threshold_in);

    // a hit reloads the count so the pulse runs from the last event
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_q <= '0;
        end else if (!detect_enable_in) begin
            cnt_q <= '0;
        end else if (hit) begin
            cnt_q <= HOLD_CNT_W'(HOLD_BASE << hold_select_in);
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end
    assign flag_out = detect_enable_in && (cnt_q != '0);

    a_flag_after_hit: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        hit ##1 detect_enable_in |-> flag_out) else $error("flag missing after hit");
    a_flag_off_disabled: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        !detect_enable_in |-> !flag_out) else $error("flag high while disabled");
    a_min_neg_mag: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        sample_in == 12'h800 |-> cmp_byte == 8'hFF) else $error("most negative code not saturated");
    a_hold_eight: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (hit && hold_select_in == 3'h0) ##1 (!hit && detect_enable_in && hold_select_in == 3'h0) [*8]
        |=> !flag_out) else $error("shortest pulse wrong length");
endmodule : range_chan
`default_nettype wire

// file: hw/mark_sync.sv
// three-stage retiming of an asynchronous level into the sample clock
// assumes the input is a raw pin level
`timescale 1ns/1ps
`default_nettype none
module mark_sync (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // level
    input wire logic async_in,
    output logic level_out
);
    import ovr_pkg::*;
    logic [SYNC_N-1:0] sync_q;
    logic level_q;

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sync_q <= '0;
        end else begin
            sync_q <= {sync_q[SYNC_N-2:0], async_in};
        end
    end
    // a change counts only once stages two and three agree
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            level_q <= 1'b0;
        end else if (sync_q[1] == sync_q[2]) begin
            level_q <= sync_q[2];
        end
    end
    assign level_out = level_q;
endmodule : mark_sync
`default_nettype wire

// file: hw/overrange_and_timestamp.sv
// top of the over-range detector and timestamp path, Avalon-MM register slave
// assumes samples come synchronous to sys_clk_in, mark input asynchronous
// Overview of operation
// - take absolute value of each 12-bit sample, compare its upper 8 bits
// - one threshold register serves all channels
// - most negative code saturates to magnitude 2047, byte 255
// - detection works only while detect enable is one
// - flag set when compared byte meets or exceeds threshold, low once the hold count runs out
// - four flag pins carry channels A, B, C, D in order
// - smaller variants use A and B, or only A
// - pulse lasts 8 shl hold select clock cycles after last event
// - mark input retimed into the sample clock domain
// - mark and samples share the same pipeline latency
// - trigger output repeats mark only when enabled with source three
// - mark goes into link words only while insertion enabled
// - mark replaces bit 0, sample upper 11 bits go to 11:1
// - mark receiver enable gates every mark function
// - divided reference on C or D pin beats the flag
`timescale 1ns/1ps
`default_nettype none
module overrange_and_timestamp (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // avalon-mm slave
    input wire logic [ovr_pkg::ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [ovr_pkg::DATA_W-1:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [ovr_pkg::DATA_W-1:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    output logic irq_out,
    // samples per channel
    input wire logic [ovr_pkg::SAMPLE_W-1:0] chan_a_sample_in,
    input wire logic [ovr_pkg::SAMPLE_W-1:0] chan_b_sample_in,
    input wire logic [ovr_pkg::SAMPLE_W-1:0] chan_c_sample_in,
    input wire logic [ovr_pkg::SAMPLE_W-1:0] chan_d_sample_in,
    // divided reference clock inputs for the C and D pins
    input wire logic divided_ref_c_in,
    input wire logic divided_ref_d_in,
    // mark
    input wire logic mark_input_in,
    // flags
    output logic chan_a_range_flag_out,
    output logic chan_b_range_flag_out,
    output logic chan_c_range_flag_out,
    output logic chan_d_range_flag_out,
    // link words and trigger
    output logic [ovr_pkg::SAMPLE_W-1:0] link_a_word_out,
    output logic [ovr_pkg::SAMPLE_W-1:0] link_b_word_out,
    output logic [ovr_pkg::SAMPLE_W-1:0] link_c_word_out,
    output logic [ovr_pkg::SAMPLE_W-1:0] link_d_word_out,
    output logic trigger_output_out
);
    import ovr_pkg::*;
    // ****************************************************************
    // registers
    // ****************************************************************
    logic [CTRL_W-1:0] ctrl_q;
    logic [CMP_W-1:0] overrange_threshold_q;
    logic [STAT_W-1:0] status_q;
    logic [STAT_W-1:0] mask_q;
    logic [DATA_W-1:0] rdata_q;
    logic ack_q;
    logic access;
    logic wr_now;
    logic overrange_detect_enable;
    logic [HOLD_SEL_W-1:0] overrange_hold_select;
    logic mark_receiver_enable;
    logic insert_enable;
    logic trigger_output_enable;
    logic [1:0] trigger_output_source;
    logic divided_ref_on_c;
    logic divided_ref_on_d;

    assign overrange_detect_enable = ctrl_q[CTRL_DET_EN];
    assign overrange_hold_select = ctrl_q[CTRL_HOLD_LO +: HOLD_SEL_W];
    assign mark_receiver_enable = ctrl_q[CTRL_RECV_EN];
    assign insert_enable = ctrl_q[CTRL_INS_EN];
    assign trigger_output_enable = ctrl_q[CTRL_TRIG_EN];
    assign trigger_output_source = ctrl_q[CTRL_TRIG_SRC_LO +: 2];
    assign divided_ref_on_c = ctrl_q[CTRL_DIVIDED_REF_ON_C];
    assign divided_ref_on_d = ctrl_q[CTRL_DIVIDED_REF_ON_D];

    // one wait cycle per access keeps read data registered
    assign access = (avs_read_in || avs_write_in) && !ack_q;
    assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !ack_q;
    assign wr_now = avs_write_in && !ack_q;

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= access;
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_q <= '0;
        end else if (wr_now && avs_address_in == REG_CTRL) begin
            if (avs_byteenable_in[0]) begin
                ctrl_q[7:0] <= avs_writedata_in[7:0];
            end
            if (avs_byteenable_in[1]) begin
                ctrl_q[CTRL_W-1:8] <= avs_writedata_in[CTRL_W-1:8];
            end
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            overrange_threshold_q <= THRESH_RESET;
        end else if (wr_now && avs_address_in == REG_THRESH && avs_byteenable_in[0]) begin
            overrange_threshold_q <= avs_writedata_in[CMP_W-1:0];
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            mask_q <= '0;
        end else if (wr_now && avs_address_in == REG_MASK && avs_byteenable_in[0]) begin
            mask_q <= avs_writedata_in[STAT_W-1:0];
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_q <= '0;
        end else if (avs_read_in && !ack_q) begin
            unique case (avs_address_in)
                REG_CTRL: rdata_q <= DATA_W'(ctrl_q);
                REG_THRESH: rdata_q <= DATA_W'(overrange_threshold_q);
                REG_STATUS: rdata_q <= DATA_W'(status_q);
                REG_MASK: rdata_q <= DATA_W'(mask_q);
                default: rdata_q <= '0;
            endcase
        end
    end
    assign avs_readdata_out = rdata_q;

    // ****************************************************************
    // channels
    // ****************************************************************
    logic [SAMPLE_W-1:0] samples [CHAN_N];
    logic [CHAN_N-1:0] flags;
    assign samples[0] = chan_a_sample_in;
    assign samples[1] = chan_b_sample_in;
    assign samples[2] = chan_c_sample_in;
    assign samples[3] = chan_d_sample_in;

    genvar gi;
    generate
        for (gi = 0; gi < CHAN_N; gi++) begin : g_chan
            range_chan u_chan (
                .sys_clk_in(sys_clk_in),
                .rst_in(rst_in),
                .detect_enable_in(overrange_detect_enable),
                .threshold_in(overrange_threshold_q),
                .hold_select_in(overrange_hold_select),
                .sample_in(samples[gi]),
                .flag_out(flags[gi])
            );
        end
    endgenerate

    assign chan_a_range_flag_out = flags[0];
    assign chan_b_range_flag_out = flags[1];
    assign chan_c_range_flag_out = divided_ref_on_c ? divided_ref_c_in : flags[2];
    assign chan_d_range_flag_out = divided_ref_on_d ? divided_ref_d_in : flags[3];

    // ****************************************************************
    // mark path
    // ****************************************************************
    logic mark_level;
    logic mark_q;
    logic [SAMPLE_W-1:0] dly_q [CHAN_N][SYNC_N+2];

    mark_sync u_mark (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .async_in(mark_input_in),
        .level_out(mark_level)
    );

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            mark_q <= 1'b0;
        end else begin
            mark_q <= mark_receiver_enable && mark_level;
        end
    end

    // samples see as many stages as the mark: three sync, filter, gate
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int c = 0; c < CHAN_N; c++) begin
                for (int s = 0; s <= SYNC_N + 1; s++) begin
                    dly_q[c][s] <= '0;
                end
            end
        end else begin
            for (int c = 0; c < CHAN_N; c++) begin
                dly_q[c][0] <= samples[c];
                for (int s = 1; s <= SYNC_N + 1; s++) begin
                    dly_q[c][s] <= dly_q[c][s-1];
                end
            end
        end
    end

    logic [SAMPLE_W-1:0] words_q [CHAN_N];
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int c = 0; c < CHAN_N; c++) begin
                words_q[c] <= '0;
            end
        end else begin
            for (int c = 0; c < CHAN_N; c++) begin
                if (insert_enable) begin
                    words_q[c] <= {dly_q[c][SYNC_N+1][SAMPLE_W-1:1], mark_q};
                end else begin
                    words_q[c] <= dly_q[c][SYNC_N+1];
                end
            end
        end
    end
    assign link_a_word_out = words_q[0];
    assign link_b_word_out = words_q[1];
    assign link_c_word_out = words_q[2];
    assign link_d_word_out = words_q[3];

    logic trig_q;
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            trig_q <= 1'b0;
        end else begin
            trig_q <= trigger_output_enable && (trigger_output_source == TRIG_SRC_MARK) && mark_q;
        end
    end
    assign trigger_output_out = trig_q;

    // ****************************************************************
    // interrupts
    // ****************************************************************
    logic [CHAN_N-1:0] flags_prev_q;
    logic mark_prev_q;
    logic [STAT_W-1:0] events;
    logic [STAT_W-1:0] clr;
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            flags_prev_q <= '0;
            mark_prev_q <= 1'b0;
        end else begin
            flags_prev_q <= flags;
            mark_prev_q <= mark_q;
        end
    end
    assign events = {mark_q && !mark_prev_q, flags & ~flags_prev_q};
    assign clr = (wr_now && avs_address_in == REG_STATUS && avs_byteenable_in[0])
        ? avs_writedata_in[STAT_W-1:0] : '0;
    // set wins over a clear in the same cycle
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            status_q <= '0;
        end else begin
            status_q <= (status_q & ~clr) | events;
        end
    end
    assign irq_out = |(status_q & mask_q);

    // ****************************************************************
    // checks
    // ****************************************************************
    a_trig_gated: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        trigger_output_out |-> $past(trigger_output_enable) && $past(trigger_output_source) == TRIG_SRC_MARK)
        else $error("trigger without enable and source");
    a_trig_follows: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (mark_q && trigger_output_enable && trigger_output_source == TRIG_SRC_MARK) |=> trigger_output_out)
        else $error("trigger did not repeat mark");
    a_recv_gate: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        !$past(mark_receiver_enable) |-> !mark_q) else $error("mark passed while receiver off");
    a_insert_lsb: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        $past(insert_enable) |-> link_a_word_out[0] == $past(mark_q)) else $error("mark not in bit 0");
    a_no_insert: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        $past(!insert_enable) |-> link_b_word_out == $past(dly_q[1][SYNC_N+1])) else $error("word altered");
    a_latency_match: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        ##6 !$past(insert_enable) |-> link_a_word_out == $past(chan_a_sample_in, 6))
        else $error("sample latency wrong");
    a_divided_ref_on_c: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        divided_ref_on_c |-> chan_c_range_flag_out == divided_ref_c_in) else $error("divided_ref_on_c lost");
    a_status_set: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (|events) |=> ((status_q & $past(events)) == $past(events))) else $error("status event lost");
endmodule : overrange_and_timestamp
`default_nettype wire

// file: testbench/gain_partner.sv
// downstream gain logic model: times flag pulses, watches link samples
// assumes flag and link word are synchronous to sys_clk_in
`timescale 1ns/1ps
`default_nettype none
module gain_partner (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // from device
    input wire logic flag_in,
    input wire logic [ovr_pkg::SAMPLE_W-1:0] word_in,
    // results
    output logic [15:0] pulse_len_out,
    output logic pulse_done_out,
    output logic gain_low_out
);
    import ovr_pkg::*;
    logic [15:0] len_q;
    logic [2:0] quiet_q;
    // ****************************************************************
    // pulse timing and gain
    // ****************************************************************
    assign pulse_len_out = len_q;
    assign pulse_done_out = !flag_in && len_q != 16'h0000;
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            len_q <= 16'h0000;
        end else begin
            len_q <= flag_in ? len_q + 16'h0001 : 16'h0000;
        end
    end
    // gain is raised only after the words themselves look quiet again
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            quiet_q <= 3'h0;
            gain_low_out <= 1'b0;
        end else begin
            quiet_q <= (word_in[11] != word_in[10]) ? 3'h0 : (quiet_q == 3'h7) ? 3'h7 : quiet_q + 3'h1;
            gain_low_out <= flag_in || (gain_low_out && quiet_q != 3'h7);
        end
    end
endmodule : gain_partner
`default_nettype wire

// file: testbench/overrange_and_timestamp_tb.sv
// self-checking bench for the over-range and timestamp block
// assumes the design files and gain_partner are compiled first
`timescale 1ns/1ps
`default_nettype none
module overrange_and_timestamp_tb;
    import ovr_pkg::*;
    logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, drc = 1'b0, drd = 1'b0, mark = 1'b0;
    logic [ADDR_W-1:0] adr = 4'h0;
    logic [DATA_W-1:0] wdat = 32'h0, rdata;
    logic [3:0] be = 4'hF;
    logic wait_rq, irq, trig, pdone, glow;
    logic [SAMPLE_W-1:0] smp [CHAN_N] = '{default: 12'h000};
    logic [SAMPLE_W-1:0] wa, wb, wc, wdd;
    logic [CHAN_N-1:0] flg;
    logic [15:0] plen;
    logic [31:0] lfsr_q = 32'hBAE6;
    logic [31:0] rq [$];
    logic [15:0] pq [$];
    int n_mismatch = 0;
    int num_checks = 0;
    logic [10:0] ctab [6] = '{11'h1F0, 11'h1F0, 11'h1D0, 11'h1E0, 11'h170, 11'h1B0};
    logic [5:0] mtab = 6'h3D;
    logic [11:0] wtab [6] = '{12'hAB5, 12'hAB4, 12'hAB5, 12'hAB4, 12'hAB5, 12'hAB5};
    logic [5:0] ttab = 6'h05;
    always #20 clk = ~clk;
    overrange_and_timestamp u_dut (
        .sys_clk_in(clk), .rst_in(rst),
        .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
        .avs_writedata_in(wdat), .avs_byteenable_in(be),
        .avs_readdata_out(rdata), .avs_waitrequest_out(wait_rq), .irq_out(irq),
        .chan_a_sample_in(smp[0]), .chan_b_sample_in(smp[1]),
        .chan_c_sample_in(smp[2]), .chan_d_sample_in(smp[3]),
        .divided_ref_c_in(drc), .divided_ref_d_in(drd), .mark_input_in(mark),
        .chan_a_range_flag_out(flg[0]), .chan_b_range_flag_out(flg[1]),
        .chan_c_range_flag_out(flg[2]), .chan_d_range_flag_out(flg[3]),
        .link_a_word_out(wa), .link_b_word_out(wb), .link_c_word_out(wc),
        .link_d_word_out(wdd), .trigger_output_out(trig)
    );
    gain_partner u_gain (
        .sys_clk_in(clk), .rst_in(rst), .flag_in(flg[0]), .word_in(wa),
        .pulse_len_out(plen), .pulse_done_out(pdone), .gain_low_out(glow)
    );
    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr_next
    function automatic logic [7:0] cmp_byte(input logic [11:0] s);
        logic [11:0] m;
        m = s[11] ? ~s + 12'h001 : s;
        if (s == 12'h800) m = 12'h7FF;
        return m[10:3];
    endfunction : cmp_byte
    // the master never assumes a latency; the loop bound is only a hang guard
    task automatic bus_wait();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wait_rq !== 1'b0 && n < 20);
        if (n >= 20) check(32'h1, 32'h0);
    endtask : bus_wait
    task automatic bus_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        adr <= a;
        wdat <= d;
        wr <= 1'b1;
        bus_wait();
        wr <= 1'b0;
    endtask : bus_write
    task automatic bus_read(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        rq.push_back(e);
        @(posedge clk);
        adr <= a;
        rd <= 1'b1;
        bus_wait();
        rd <= 1'b0;
    endtask : bus_read
    task automatic hit_a();
        @(posedge clk);
        smp[0] <= 12'h7FF;
        @(posedge clk);
        smp[0] <= 12'h000;
    endtask : hit_a
    // flags are looked at just after the edge that takes the sample, then left to expire
    task automatic hit_check(input logic [7:0] thr, input logic en, input logic [11:0] v0, v1, v2, v3);
        logic [SAMPLE_W-1:0] v [CHAN_N];
        v = '{v0, v1, v2, v3};
        if (cmp_byte(v0) >= thr && en) pq.push_back(16'h0008);
        @(posedge clk);
        for (int c = 0; c < CHAN_N; c++) smp[c] <= v[c];
        @(posedge clk);
        for (int c = 0; c < CHAN_N; c++) smp[c] <= 12'h000;
        #1;
        for (int c = 0; c < CHAN_N; c++) check(32'(flg[c]), 32'(cmp_byte(v[c]) >= thr && en));
        repeat (12) @(posedge clk);
    endtask : hit_check
    // ****************************************************************
    // scoreboard and watchdog
    // ****************************************************************
    always @(posedge clk) begin
        if (rd && wait_rq === 1'b0) check(rdata, rq.pop_front());
        if (pdone === 1'b1) check(32'(plen), 32'(pq.pop_front()));
    end
    initial begin
        repeat (40000) @(posedge clk);
        n_mismatch++;
        print_verdict();
    end
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        bus_read(REG_THRESH, 32'h0000_00FF);
        bus_read(REG_STATUS, 32'h0000_0000);
        bus_write(4'h2, 32'hFFFF_FFFF);
        bus_read(4'h2, 32'h0000_0000);
        hit_check(8'hFF, 1'b0, 12'h7FF, 12'h800, 12'h7FF, 12'h800);
        bus_write(REG_CTRL, 32'h0000_0001);
        hit_check(8'hFF, 1'b1, 12'h7FF, 12'h800, 12'h7F0, 12'h810);
        bus_write(REG_THRESH, 32'h0000_00FE);
        hit_check(8'hFE, 1'b1, 12'h7F0, 12'h810, 12'h7EF, 12'h000);
        bus_write(REG_THRESH, 32'h0000_00E4);
        for (int i = 0; i < 16; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            hit_check(8'hE4, 1'b1, lfsr_q[11:0], lfsr_q[23:12], lfsr_q[11:0] ^ 12'h7C0, ~lfsr_q[23:12]);
        end
        for (int s = 0; s < 8; s++) begin
            bus_write(REG_CTRL, 32'(1 + (s << 1)));
            pq.push_back(16'(8 << s));
            hit_a();
            repeat ((8 << s) + 12) @(posedge clk);
        end
        bus_write(REG_CTRL, 32'h0000_0001);
        pq.push_back(16'h000C);
        hit_a();
        repeat (2) @(posedge clk);
        hit_a();
        repeat (24) @(posedge clk);
        bus_write(REG_STATUS, 32'h0000_001F);
        bus_read(REG_STATUS, 32'h0000_0000);
        pq.push_back(16'h0008);
        hit_a();
        repeat (12) @(posedge clk);
        bus_read(REG_STATUS, 32'h0000_0001);
        check(32'(irq), 32'h0);
        bus_write(REG_MASK, 32'h0000_0001);
        #1 check(32'(irq), 32'h1);
        bus_write(REG_STATUS, 32'h0000_0001);
        #1 check(32'(irq), 32'h0);
        bus_write(REG_CTRL, 32'h0000_0601);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            drc <= i[0];
            drd <= ~i[0];
            #1 check(32'({flg[3], flg[2]}), 32'({~i[0], i[0]}));
        end
        @(posedge clk);
        smp[0] <= 12'hAB5;
        for (int i = 0; i < 6; i++) begin
            bus_write(REG_CTRL, 32'(ctab[i]));
            mark <= mtab[i];
            repeat (12) @(posedge clk);
            #1 check(32'({trig, wa}), 32'({ttab[i], wtab[i]}));
        end
        bus_write(REG_CTRL, 32'h0000_01F0);
        mark <= 1'b0;
        repeat (12) @(posedge clk);
        smp[0] <= 12'h354;
        mark <= 1'b1;
        for (int i = 0; i < 12 && wa === 12'hAB4; i++) begin
            @(posedge clk);
            #1;
        end
        check(32'(wa), 32'h0000_0355);
        check(32'(wb), 32'h0000_0001);
        check(32'({wc, wdd}), 32'h0000_1001);
        smp[0] <= 12'h000;
        repeat (16) @(posedge clk);
        #1 check(32'(glow), 32'h0);
        print_verdict();
    end
endmodule : overrange_and_timestamp_tb
`default_nettype wire
